// File: design/ormp_pkg.sv
// constants, encodings and state types for the or/move/load-pointer executor
package ormp_pkg;
  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 12;
  localparam int          BANK_W        = 4;
  localparam int          NUM_PTRS      = 3;
  localparam int          PSEL_W        = 2;
  // opcode field positions and patterns
  localparam int          OPC6_MSB      = 15;
  localparam int          OPC6_LSB      = 10;
  localparam logic [5:0]  OPC_OR_FILE   = 6'h04;
  localparam logic [5:0]  OPC_MOVE_FILE = 6'h14;
  localparam int          OPC8_MSB      = 15;
  localparam int          OPC8_LSB      = 8;
  localparam logic [7:0]  OPC_LOAD_PTR  = 8'hEE;
  localparam logic [7:0]  OPC_LIT_WORD2 = 8'hF0;
  localparam int          LDP_ZERO_MSB  = 7;
  localparam int          LDP_ZERO_LSB  = 6;
  localparam int          PSEL_LSB      = 4;
  localparam int          LIT_HI_MSB    = 3;
  localparam int          DEST_BIT      = 9;
  localparam int          ACCESS_BIT    = 8;
  localparam int          FILE_MSB      = 7;
  localparam logic        DEST_WORK     = 1'b0;
  localparam logic        ACCESS_FIXED  = 1'b0;
  // addressing constants
  localparam logic [7:0]  INDEX_LIMIT   = 8'h5F;
  localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
  localparam logic [3:0]  ACCESS_LO_BNK = 4'h0;
  localparam logic [3:0]  ACCESS_HI_BNK = 4'hF;
  localparam logic [1:0]  INDEX_PTR     = 2'h2;
  // reset values
  localparam logic [7:0]  WORK_RST      = 8'h00;
  localparam logic [11:0] PTR_RST       = 12'h000;
  localparam logic [11:0] ADDR_RST      = 12'h000;

  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } ormp_phase_e;

  typedef enum logic [1:0] {
    SQ_FIRST  = 2'h1,
    SQ_SECOND = 2'h2
  } ormp_seq_e;

  typedef enum logic [3:0] {
    OP_NONE = 4'h1,
    OP_OR   = 4'h2,
    OP_MOVE = 4'h4,
    OP_LDP  = 4'h8
  } ormp_op_e;
endpackage : ormp_pkg

// File: design/ormp_ptr_if.sv
// write port and read-back of the indirect pointer bank
`timescale 1ns/1ns
`default_nettype none
interface ormp_ptr_if;
  logic                 wr_hi;
  logic                 wr_lo;
  logic [1:0]           wr_sel;
  logic [7:0]           wr_data;
  logic [2:0][11:0]     ptr;

  modport bank (input wr_hi, input wr_lo, input wr_sel, input wr_data, output ptr);
  modport user (output wr_hi, output wr_lo, output wr_sel, output wr_data, input ptr);
endinterface : ormp_ptr_if
`default_nettype wire

// File: design/ormp_ptr_bank.sv
// three 12-bit indirect pointer registers with byte-wise write
`timescale 1ns/1ns
`default_nettype none
module ormp_ptr_bank (
  input  wire logic   i_sys_clk,
  input  wire logic   i_rst,
  ormp_ptr_if.bank    pif
);
  import ormp_pkg::*;

  genvar g;
  generate
    for (g = 0; g < NUM_PTRS; g++) begin : g_ptr
      logic [ADDR_W-1:0] ptr_reg;
      always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
          ptr_reg <= PTR_RST;
        end else if (pif.wr_hi && (pif.wr_sel == PSEL_W'(g))) begin
          // high byte holds only the upper literal nibble
          ptr_reg[ADDR_W-1:DATA_W] <= pif.wr_data[LIT_HI_MSB:0];
        end else if (pif.wr_lo && (pif.wr_sel == PSEL_W'(g))) begin
          ptr_reg[DATA_W-1:0] <= pif.wr_data;
        end
      end
      assign pif.ptr[g] = ptr_reg;
    end
  endgenerate
endmodule : ormp_ptr_bank
`default_nettype wire

// File: design/ormp_exec.sv
// four-phase executor for or-with-file, move-file and load-pointer-literal
//
// Behaviour
// - or opcode: working OR file to destination
// - destination bit 0 working, 1 file
// - access bit 0 uses fixed access bank
// - access bit 1 uses bank select plus file
// - extended mode, low offsets index from pointer
// - move opcode copies file to destination
// - move file field reaches full bank
// - load pointer: 12-bit literal, selected pointer
`timescale 1ns/1ns
`default_nettype none
module ormp_exec (
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_rst,
  input  wire logic                          i_instr_valid,
  input  wire logic [15:0]                   i_instr,
  input  wire logic                          i_ext_mode,
  input  wire logic [ormp_pkg::BANK_W-1:0]   i_bank_select_reg,
  input  wire logic [ormp_pkg::DATA_W-1:0]   i_mem_rdata,
  output logic                               o_instr_ready,
  output logic [ormp_pkg::ADDR_W-1:0]        o_mem_addr,
  output logic                               o_mem_rd,
  output logic                               o_mem_wr,
  output logic [ormp_pkg::DATA_W-1:0]        o_mem_wdata,
  output logic [ormp_pkg::DATA_W-1:0]        o_work_reg,
  output logic                               o_flag_n,
  output logic                               o_flag_z,
  output logic [ormp_pkg::ADDR_W-1:0]        o_ptr0,
  output logic [ormp_pkg::ADDR_W-1:0]        o_ptr1,
  output logic [ormp_pkg::ADDR_W-1:0]        o_ptr2
);
  import ormp_pkg::*;

  function automatic ormp_op_e op_of(input logic [15:0] w);
    ormp_op_e op;
    op = OP_NONE;
    if (w[OPC6_MSB:OPC6_LSB] == OPC_OR_FILE) begin
      op = OP_OR;
    end else if (w[OPC6_MSB:OPC6_LSB] == OPC_MOVE_FILE) begin
      op = OP_MOVE;
    end else if ((w[OPC8_MSB:OPC8_LSB] == OPC_LOAD_PTR) && (w[LDP_ZERO_MSB:LDP_ZERO_LSB] == 2'h0)) begin
      op = OP_LDP;
    end
    return op;
  endfunction : op_of

  function automatic logic [ADDR_W-1:0] data_addr(input logic [15:0] w, input logic ext,
                                                  input logic [BANK_W-1:0] bsel,
                                                  input logic [ADDR_W-1:0] base);
    logic [7:0]        f;
    logic [ADDR_W-1:0] a;
    f = w[FILE_MSB:0];
    a = {bsel, f};
    if (w[ACCESS_BIT] == ACCESS_FIXED) begin
      if (ext && (f <= INDEX_LIMIT)) begin
        a = ADDR_W'(base + {4'h0, f});
      end else if (f < ACCESS_SPLIT) begin
        a = {ACCESS_LO_BNK, f};
      end else begin
        a = {ACCESS_HI_BNK, f};
      end
    end else begin
      // bank select with full file field
      a = {bsel, f};
    end
    return a;
  endfunction : data_addr

  ormp_ptr_if pif ();

  ormp_phase_e        phase_reg;
  ormp_seq_e          seq_reg;
  ormp_op_e           op_reg;
  logic               dest_reg;
  logic [PSEL_W-1:0]  psel_reg;
  logic [3:0]         lit_hi_reg;
  logic [DATA_W-1:0]  lit_lo_reg;
  logic [DATA_W-1:0]  result_reg;
  logic [ADDR_W-1:0]  mem_addr_reg;
  logic               mem_rd_reg;
  logic               mem_wr_reg;
  logic [DATA_W-1:0]  work_reg;
  logic               flag_n_reg;
  logic               flag_z_reg;
  logic               take;
  logic               take_second;
  logic               file_op;
  logic [DATA_W-1:0]  result_next;

  assign o_instr_ready = (phase_reg == PH_Q1);
  assign take          = o_instr_ready && i_instr_valid && (seq_reg == SQ_FIRST);
  // second word is taken as the literal whatever its prefix
  assign take_second   = o_instr_ready && i_instr_valid && (seq_reg == SQ_SECOND);
  assign file_op       = (op_reg == OP_OR) || (op_reg == OP_MOVE);

  // four phases per instruction cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      phase_reg <= PH_Q1;
    end else begin
      unique case (phase_reg)
        PH_Q1: phase_reg <= PH_Q2;
        PH_Q2: phase_reg <= PH_Q3;
        PH_Q3: phase_reg <= PH_Q4;
        PH_Q4: phase_reg <= PH_Q1;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      seq_reg <= SQ_FIRST;
    end else if (take && (op_of(i_instr) == OP_LDP)) begin
      seq_reg <= SQ_SECOND;
    end else if (take_second) begin
      seq_reg <= SQ_FIRST;
    end
  end

  // instruction capture in Q1, retired after Q4
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      op_reg     <= OP_NONE;
      dest_reg   <= DEST_WORK;
      psel_reg   <= 2'h0;
      lit_hi_reg <= 4'h0;
      lit_lo_reg <= 8'h00;
    end else if (take) begin
      op_reg     <= op_of(i_instr);
      dest_reg   <= i_instr[DEST_BIT];
      psel_reg   <= i_instr[PSEL_LSB+PSEL_W-1:PSEL_LSB];
      lit_hi_reg <= i_instr[LIT_HI_MSB:0];
    end else if (take_second) begin
      op_reg     <= OP_LDP;
      lit_lo_reg <= i_instr[DATA_W-1:0];
    end else if (phase_reg == PH_Q4) begin
      op_reg     <= OP_NONE;
    end
  end

  // address formed at decode, read strobe during Q2
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      mem_addr_reg <= ADDR_RST;
      mem_rd_reg   <= 1'b0;
    end else if (take) begin
      mem_addr_reg <= data_addr(i_instr, i_ext_mode, i_bank_select_reg, pif.ptr[INDEX_PTR]);
      mem_rd_reg   <= (op_of(i_instr) == OP_OR) || (op_of(i_instr) == OP_MOVE);
    end else begin
      mem_rd_reg   <= 1'b0;
    end
  end

  always_comb begin
    result_next = i_mem_rdata;
    if (op_reg == OP_OR) begin
      result_next = work_reg | i_mem_rdata;
    end else if (op_reg == OP_MOVE) begin
      result_next = i_mem_rdata;
    end
  end

  // read data arrive in Q3; file write strobe during Q4
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      result_reg <= 8'h00;
      mem_wr_reg <= 1'b0;
    end else if ((phase_reg == PH_Q3) && file_op) begin
      result_reg <= result_next;
      mem_wr_reg <= (dest_reg != DEST_WORK);
    end else begin
      mem_wr_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      work_reg <= WORK_RST;
    end else if ((phase_reg == PH_Q4) && file_op && (dest_reg == DEST_WORK)) begin
      work_reg <= result_reg;
    end
  end

  // flags from result, untouched by load
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      flag_n_reg <= 1'b0;
      flag_z_reg <= 1'b0;
    end else if ((phase_reg == PH_Q4) && file_op) begin
      flag_n_reg <= result_reg[DATA_W-1];
      flag_z_reg <= (result_reg == 8'h00);
    end
  end

  // high nibble first word, low byte second
  assign pif.wr_hi   = (phase_reg == PH_Q4) && (op_reg == OP_LDP) && (seq_reg == SQ_SECOND);
  assign pif.wr_lo   = (phase_reg == PH_Q4) && (op_reg == OP_LDP) && (seq_reg == SQ_FIRST);
  assign pif.wr_sel  = psel_reg;
  assign pif.wr_data = pif.wr_hi ? {4'h0, lit_hi_reg} : lit_lo_reg;

  ormp_ptr_bank u_ptr_bank (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .pif       (pif)
  );

  assign o_mem_addr  = mem_addr_reg;
  assign o_mem_rd    = mem_rd_reg;
  assign o_mem_wr    = mem_wr_reg;
  assign o_mem_wdata = result_reg;
  assign o_work_reg  = work_reg;
  assign o_flag_n    = flag_n_reg;
  assign o_flag_z    = flag_z_reg;
  assign o_ptr0      = pif.ptr[0];
  assign o_ptr1      = pif.ptr[1];
  assign o_ptr2      = pif.ptr[2];
endmodule : ormp_exec
`default_nettype wire

// File: tb/ormp_exec_monitor.sv
// port assertions for the or/move/load-pointer executor
`timescale 1ns/1ns
`default_nettype none
module ormp_exec_monitor (
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire logic        i_instr_valid,
  input wire logic [15:0] i_instr,
  input wire logic        i_ext_mode,
  input wire logic [3:0]  i_bank_select_reg,
  input wire logic [7:0]  i_mem_rdata,
  input wire logic        o_instr_ready,
  input wire logic [11:0] o_mem_addr,
  input wire logic        o_mem_rd,
  input wire logic        o_mem_wr,
  input wire logic [7:0]  o_mem_wdata,
  input wire logic [7:0]  o_work_reg,
  input wire logic        o_flag_n,
  input wire logic        o_flag_z,
  input wire logic [11:0] o_ptr2
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  logic tk, om, mv, ld, lo;
  assign tk = o_instr_ready && i_instr_valid;
  assign mv = i_instr[15:10] == 6'h14;
  assign om = mv || i_instr[15:10] == 6'h04;
  assign ld = i_instr[15:8] == 8'hEE;
  assign lo = om && !i_instr[8] && i_instr[7:0] <= 8'h5F;
  a_ready_cycle: assert property (o_instr_ready |=> !o_instr_ready [*3] ##1 o_instr_ready)
    else $error("ready not once in four cycles");
  a_bank_addr: assert property (tk && om && i_instr[8] |=>
    o_mem_addr == {$past(i_bank_select_reg), $past(i_instr[7:0])}) else $error("bank address wrong");
  a_access_addr: assert property (tk && om && !i_instr[8] && !(i_ext_mode && lo) |=>
    o_mem_addr == {($past(i_instr[7:0]) < 8'h60) ? 4'h0 : 4'hF, $past(i_instr[7:0])})
    else $error("access bank address wrong");
  a_index_addr: assert property (tk && lo && i_ext_mode |=>
    o_mem_addr == $past(o_ptr2) + 12'($past(i_instr[7:0]))) else $error("indexed address wrong");
  a_dest_write: assert property (tk && om |=> ##2 o_mem_wr == $past(i_instr[9], 3))
    else $error("write strobe wrong");
  a_move_copy: assert property (tk && mv && i_instr[9] |=> ##2 o_mem_wdata == $past(i_mem_rdata))
    else $error("moved byte altered");
  a_or_work: assert property (tk && om && !mv && !i_instr[9] |=> ##3
    o_work_reg == ($past(o_work_reg, 4) | $past(i_mem_rdata, 2))) else $error("or result wrong");
  a_flags_work: assert property (tk && om && !i_instr[9] |=> ##3
    o_flag_n == o_work_reg[7] && o_flag_z == (o_work_reg == 8'h00)) else $error("flags wrong");
  a_load_quiet: assert property (tk && ld |=> (!o_mem_rd && $stable({o_flag_n, o_flag_z}))[*4])
    else $error("load pointer touched memory or flags");
  a_load_high: assert property (tk && ld && i_instr[5:4] == 2'h2 |=> ##3
    o_ptr2[11:8] == $past(i_instr[3:0], 4)) else $error("pointer high nibble wrong");
  cover property (tk && ld);
  cover property (tk && lo && i_ext_mode);
  cover property (o_mem_wr);
endmodule : ormp_exec_monitor
bind ormp_exec ormp_exec_monitor ormp_exec_monitor_inst (.i_sys_clk, .i_rst, .i_instr_valid, .i_instr,
  .i_ext_mode, .i_bank_select_reg, .i_mem_rdata, .o_instr_ready, .o_mem_addr, .o_mem_rd, .o_mem_wr,
  .o_mem_wdata, .o_work_reg, .o_flag_n, .o_flag_z, .o_ptr2);
`default_nettype wire

// File: tb/test_ormp_exec.sv
// self-checking bench for the or/move/load-pointer executor
`timescale 1ns/1ns
`default_nettype none
module test_ormp_exec;
  import ormp_pkg::*;
  typedef struct packed {logic [15:0] ins; logic [7:0] rd; logic ext; logic [3:0] bank_select_reg; logic [11:0] adr;} ormp_row_s;
  logic        clk = 1'b0, rst = 1'b1, vld = 1'b0, ext = 1'b0, n_m = 1'b0, z_m = 1'b0;
  logic [15:0] ins = 16'h0000;
  logic [3:0]  bank_select_reg = 4'h0;
  logic [7:0]  rdat = 8'h00, w_m = 8'h00, wd, w;
  logic        rdy, rd, wr, fn, fz;
  logic [11:0] adr, p0, p1, p2;
  int          miscompares = 0, checks_done = 0, cyc = 0;
  ormp_row_s   rows[7] = '{'{16'h5145, 8'h91, 1'b0, 4'h2, 12'h245}, '{16'h1113, 8'h13, 1'b0, 4'h3, 12'h313},
    '{16'h125F, 8'h04, 1'b0, 4'h0, 12'h05F}, '{16'h5260, 8'h00, 1'b0, 4'h0, 12'hF60},
    '{16'h5060, 8'h22, 1'b1, 4'h0, 12'hF60}, '{16'h51FF, 8'h00, 1'b0, 4'hF, 12'hFFF},
    '{16'h1000, 8'h80, 1'b0, 4'h0, 12'h000}};
  ormp_exec ormp_exec_inst (.i_sys_clk(clk), .i_rst(rst), .i_instr_valid(vld), .i_instr(ins), .i_ext_mode(ext),
    .i_bank_select_reg(bank_select_reg), .i_mem_rdata(rdat), .o_instr_ready(rdy), .o_mem_addr(adr), .o_mem_rd(rd),
    .o_mem_wr(wr), .o_mem_wdata(wd), .o_work_reg(w), .o_flag_n(fn), .o_flag_z(fz), .o_ptr0(p0), .o_ptr1(p1),
    .o_ptr2(p2));
  initial forever #20 clk = ~clk;
  task results;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      results;
    end
  end
  task chk(string nm, logic [11:0] e, logic [11:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // valid held until the edge that samples ready high
  task issue(logic [15:0] x);
    @(posedge clk); vld <= 1'b1; ins <= x;
    do @(negedge clk); while (rdy !== 1'b1);
    @(posedge clk); vld <= 1'b0;
  endtask : issue
  task run_op(ormp_row_s r);
    logic [7:0] res;
    @(posedge clk); ext <= r.ext; bank_select_reg <= r.bank_select_reg; rdat <= r.rd;
    res = r.ins[14] ? r.rd : (w_m | r.rd);
    issue(r.ins);
    @(negedge clk); chk("rd", 12'(1'b1), 12'(rd));
    chk("addr", r.adr, adr);
    @(negedge clk); @(posedge clk); rdat <= ~r.rd;
    @(negedge clk); chk("wr", 12'(r.ins[9]), 12'(wr));
    if (r.ins[9]) chk("wdata", 12'(res), 12'(wd));
    if (!r.ins[9]) w_m = res;
    n_m = res[7]; z_m = res == 8'h00;
    @(negedge clk); chk("work", 12'(w_m), 12'(w));
    chk("flags", 12'({n_m, z_m}), 12'({fn, fz}));
  endtask : run_op
  task chkp(logic [2:0][11:0] e);
    chk("ptr0", e[0], p0);
    chk("ptr1", e[1], p1);
    chk("ptr2", e[2], p2);
    chk("flags", 12'({n_m, z_m}), 12'({fn, fz}));
  endtask : chkp
  task ldp(logic [1:0] s, logic [11:0] k);
    logic [2:0][11:0] e;
    e = {p2, p1, p0};
    issue({8'hEE, 2'h0, s, k[11:8]});
    repeat (4) @(negedge clk);
    if (s != 2'h3) e[s][11:8] = k[11:8];
    chkp(e);
    issue({8'hF0, k[7:0]});
    repeat (4) @(negedge clk);
    if (s != 2'h3) e[s][7:0] = k[7:0];
    chkp(e);
  endtask : ldp
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk); chk("ready", 12'(1'b1), 12'(rdy));
    chkp('0);
    foreach (rows[i]) run_op(rows[i]);
    ldp(2'h0, 12'hFFF);
    ldp(2'h1, 12'h100);
    ldp(2'h3, 12'h5A5);
    ldp(2'h2, 12'h3AB);
    // unknown opcode is taken but must touch nothing
    issue(16'hC000);
    @(negedge clk); chk("rd", 12'h000, 12'(rd));
    repeat (2) @(negedge clk);
    chk("wr", 12'h000, 12'(wr));
    @(negedge clk); chk("work", 12'(w_m), 12'(w));
    chkp({12'h3AB, 12'h100, 12'hFFF});
    // pointer 2 plus offset 5F
    run_op('{16'h105F, 8'h01, 1'b1, 4'h0, 12'h40A});
    @(posedge clk); rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    w_m = 8'h00; n_m = 1'b0; z_m = 1'b0;
    @(negedge clk); chk("work", 12'h000, 12'(w));
    chkp('0);
    run_op(rows[0]);
    results;
  end
endmodule : test_ormp_exec
`default_nettype wire
